// >>> dv/sdcc_core_tb.sv
// Purpose: self-checking bench for the conversion control core
// Assumes: notch code 19 keeps output periods short
// Notes: bit_mode 0 all ones, 1 all zeros, 2 random bits
`timescale 1ns/1ps
module sdcc_core_tb;
  logic clk_i = 0, rst_n_i = 0, mod_bit_i = 0, sync_n_i = 1, standby_i = 0;
  logic cfg_wr_i = 0, chan_i = 0, coef_sel_i = 0, coef_wr_i = 0;
  logic [2:0] gain_i = 0;
  logic [11:0] notch_select_field_i = 0;
  logic [1:0] cal_mode_i = 0;
  logic [23:0] coef_wdata_i = 0;
  logic [23:0] data_o, coef_rdata_o;
  logic [11:0] notch_o;
  logic [2:0] gain_o;
  logic [1:0] cal_phase_o;
  logic data_ready_o, data_valid_o, cal_busy_o, cal_internal_o, mod_en_o;
  logic sample_en_o, chan_o, standby_o, cal_ovf_o;
  logic [23:0] seed = 24'h00001D;
  logic [23:0] wv;
  int bit_mode = 2, err_count = 0, tests_run = 0, p, i;
  always #20 clk_i = ~clk_i;
  sdcc_core #(.BG_GAP(1)) dut_u (.clk_i, .rst_n_i, .mod_bit_i, .sync_n_i, .standby_i,
    .cfg_wr_i, .chan_i, .gain_i, .notch_select_field_i, .cal_mode_i, .coef_sel_i,
    .coef_wr_i, .coef_wdata_i, .data_o, .data_ready_o, .data_valid_o, .coef_rdata_o,
    .cal_busy_o, .cal_phase_o, .cal_internal_o, .cal_ovf_o, .mod_en_o, .sample_en_o,
    .chan_o, .gain_o, .notch_o, .standby_o);
  sdcc_host_model host_u (.clk_i, .rst_n_i, .ready_i(data_ready_o),
    .valid_i(data_valid_o), .data_i(data_o));
  function automatic logic [23:0] lfsr(input logic [23:0] s);
    return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
  endfunction
  always @(posedge clk_i)
  begin
    seed = lfsr(seed);
    mod_bit_i <= (bit_mode == 2) ? seed[0] : (bit_mode == 0);
  end
  task automatic end_sim();
    $display("counts: %0d compares, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic hang();
    err_count++;
    $display("MISMATCH %0t wait ran out", $time);
    end_sim();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic cfg(input logic c, input logic [1:0] m);
    @(posedge clk_i);
    cfg_wr_i <= 1'b1;
    chan_i <= c;
    cal_mode_i <= m;
    @(posedge clk_i);
    cfg_wr_i <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic cw(input logic s, input logic [23:0] v);
    @(posedge clk_i);
    coef_sel_i <= s;
    coef_wr_i <= 1'b1;
    coef_wdata_i <= v;
    @(posedge clk_i);
    coef_wr_i <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // distance in cycles between two pulses of the chosen enable
  task automatic gap(input bit s);
    repeat (2)
    begin
      p = 0;
      do
      begin
        @(negedge clk_i);
        p++;
        if (p > 20000)
          hang();
      end while ((s ? sample_en_o : mod_en_o) !== 1'b1);
    end
  endtask
  task automatic rdy();
    p = 0;
    do
    begin
      @(negedge clk_i);
      p++;
      if (p > 12000)
        hang();
    end while (data_ready_o !== 1'b1);
  endtask
  task automatic settle(input int n);
    for (i = 1; i <= n; i++)
    begin
      rdy();
      chk(24'(data_valid_o), 24'(i == n), "valid flag");
    end
  endtask
  task automatic rst_cyc();
    rst_n_i <= 1'b0;
    @(negedge clk_i);
    chk(24'(notch_o), 24'(sdcc_pkg::CODE_DEF), "notch default");
    chk(24'(cal_busy_o), 24'h0, "busy in reset");
    chk(24'(cal_ovf_o), 24'h0, "ovf in reset");
    tick(3);
    rst_n_i <= 1'b1;
  endtask
  initial
  begin
    rst_cyc();
    tick(2);
    @(negedge clk_i);
    chk(coef_rdata_o, 24'h000000, "offset coef reset");
    wv = seed;
    cw(1'b0, wv);
    chk(coef_rdata_o, wv, "offset readback");
    cw(1'b1, 24'h5A3C96);
    chk(coef_rdata_o, 24'h5A3C96, "gain readback");
    cw(1'b0, 24'h000000);
    cw(1'b1, 24'h400000);
    $display("test reset and coef done");
    notch_select_field_i <= 12'h000;
    cfg(1'b0, 2'h0);
    chk(24'(notch_o), 24'(sdcc_pkg::CODE_MIN), "notch low clamp");
    notch_select_field_i <= 12'hFFF;
    cfg(1'b0, 2'h0);
    chk(24'(notch_o), 24'(sdcc_pkg::CODE_MAX), "notch high clamp");
    notch_select_field_i <= 12'h013;
    cfg(1'b0, 2'h0);
    chk(24'(notch_o), 24'h000013, "notch set");
    gap(1'b0);
    chk(24'(p), 24'(512), "modulator rate");
    for (int g = 0; g < 8; g++)
    begin
      gain_i <= 3'(g);
      cfg(1'b0, 2'h0);
      chk(24'(gain_o), 24'(g), "gain set");
      gap(1'b1);
      chk(24'(p), 24'(256 >> (g > 3 ? 3 : g)), "sample rate");
    end
    standby_i <= 1'b1;
    tick(2);
    @(negedge clk_i);
    chk(24'(standby_o), 24'h1, "standby flag");
    p = 0;
    repeat (1100)
    begin
      @(negedge clk_i);
      p += (mod_en_o === 1'b1);
    end
    chk(24'(p), 24'h0, "no activity in standby");
    standby_i <= 1'b0;
    $display("test config and rates done");
    bit_mode = 0;
    cfg(1'b1, 2'h0);
    settle(3);
    rdy();
    chk(24'(data_valid_o), 24'h1, "valid after channel change");
    chk(24'(p), 24'(19 * 512), "refresh period");
    @(negedge clk_i);
    chk(host_u.got_q[$], 24'(19 * 19 * 19), "full scale result");
    cw(1'b0, 24'(59));
    cw(1'b1, 24'h800000);
    rdy();
    @(negedge clk_i);
    chk(host_u.got_q[$], 24'((6859 - 59) * 2), "corrected result");
    cw(1'b0, 24'h000000);
    cw(1'b1, 24'h400000);
    $display("test conversion done");
    bit_mode = 1;
    sync_n_i <= 1'b0;
    tick(5);
    sync_n_i <= 1'b1;
    settle(3);
    @(negedge clk_i);
    chk(host_u.got_q[$], -24'(6859), "zero scale result");
    chk(24'(host_u.got_q.size()), 24'h000004, "settled results kept");
    chk(24'(host_u.reads), 24'h000008, "results read once each");
    $display("test sync done");
    cfg(1'b0, 2'h1);
    chk(24'(cal_busy_o), 24'h1, "self cal busy");
    chk(24'(cal_phase_o), 24'h1, "zero phase first");
    chk(24'(cal_internal_o), 24'h1, "self cal internal");
    cw(1'b0, 24'h123456);
    chk(coef_rdata_o, 24'h000000, "write refused in cal");
    cfg(1'b0, 2'h2);
    chk(24'(cal_internal_o), 24'h1, "restart refused");
    rst_cyc();
    cfg(1'b0, 2'h2);
    chk(24'(cal_internal_o), 24'h0, "system cal external");
    chk(24'(cal_busy_o), 24'h1, "system cal busy");
    rst_cyc();
    cfg(1'b0, 2'h3);
    chk(24'(cal_busy_o), 24'h1, "background cal busy");
    $display("test calibration done");
    end_sim();
  end
endmodule

// >>> dv/sdcc_host_model.sv
// Purpose: host reader of conversion results
// Assumes: one read per ready pulse
// Notes: unsettled results are dropped, not queued
`timescale 1ns/1ps
module sdcc_host_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ready_i,
  input wire logic valid_i,
  input wire logic [23:0] data_i
);
  logic [23:0] got_q[$];
  int reads = 0;
  // reads follow the refresh pulse, so never faster than refresh
  always @(posedge clk_i)
  begin
    if (rst_n_i && ready_i === 1'b1)
    begin
      reads++;
      if (valid_i === 1'b1)
        got_q.push_back(data_i);
    end
  end
endmodule

// >>> include/sdcc_pkg.sv
// Purpose: constants and types for the sigma-delta conversion control block
// Assumes: clk_i is the master clock; notch codes are decimation ratios
// Notes: notch limits are derived from the 10 MHz reference master clock
package sdcc_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int REF_CLK_HZ = 10_000_000;
  localparam int MOD_DIV = 512;
  localparam int SAMP_DIV = 256;
  localparam int SAMP_MULT_LOG_MAX = 3;
  localparam longint REF_MOD_MHZ = 64'(REF_CLK_HZ) * 1000 / MOD_DIV;
  localparam longint NOTCH_MIN_MHZ = 9_760;
  localparam longint NOTCH_MAX_MHZ = 1_028_000;
  localparam longint NOTCH_DEF_MHZ = 60_000;
  localparam logic [11:0] CODE_MAX = 12'(REF_MOD_MHZ / NOTCH_MIN_MHZ);
  localparam logic [11:0] CODE_MIN = 12'((REF_MOD_MHZ + NOTCH_MAX_MHZ - 1) / NOTCH_MAX_MHZ);
  localparam logic [11:0] CODE_DEF = 12'(REF_MOD_MHZ / NOTCH_DEF_MHZ);
  localparam logic [8:0] MOD_LAST = 9'(MOD_DIV - 1);
  localparam logic [2:0] SETTLE_STEP = 3'h4;
  localparam logic [2:0] SETTLE_CHAN = 3'h3;
  localparam logic [2:0] SETTLE_SYNC = 3'h3;
  localparam logic [2:0] SETTLE_CAL = 3'h3;
  localparam logic [2:0] SETTLE_RST = 3'h4;
  localparam logic [23:0] COEF_OFF_RST = 24'h000000;
  localparam logic [23:0] COEF_GAIN_RST = 24'h400000;
  localparam int GAIN_SHIFT = 22;
  localparam logic [5:0] DIV_TOP = 6'h2C;
  localparam int BG_GAP_DEF = 16;

  typedef enum logic [1:0] {
    SDCC_CAL_NONE = 2'h0,
    SDCC_CAL_SELF = 2'h1,
    SDCC_CAL_SYS = 2'h2,
    SDCC_CAL_BG = 2'h3
  } sdcc_cal_mode_t;

  typedef enum logic [1:0] {
    SDCC_ST_RUN = 2'h0,
    SDCC_ST_ZERO = 2'h1,
    SDCC_ST_FULL = 2'h3,
    SDCC_ST_DIV = 2'h2
  } sdcc_st_t;

  typedef struct packed {
    sdcc_st_t st;
    logic [8:0] div;
    logic mod_en;
    logic samp_en;
    logic [35:0] i1;
    logic [35:0] i2;
    logic [35:0] i3;
    logic [35:0] d1;
    logic [35:0] d2;
    logic [35:0] d3;
    logic [11:0] dec;
    logic [11:0] notch;
    logic [2:0] gain;
    logic chan;
    logic [2:0] settle;
    logic [23:0] dout;
    logic rdy;
    logic valid;
    logic [23:0] off_c;
    logic [23:0] gain_c;
    logic [23:0] span;
    logic [24:0] rem;
    logic [23:0] quo;
    logic ovf;
    logic [5:0] dcnt;
    logic sys;
    logic bg;
    logic [7:0] bgcnt;
    logic intl;
    logic busy;
    logic stby;
    logic [23:0] coef_rd;
  } sdcc_state_t;

  localparam sdcc_state_t STATE_RST = '{
    st: SDCC_ST_RUN,
    notch: CODE_DEF,
    gain_c: COEF_GAIN_RST,
    off_c: COEF_OFF_RST,
    settle: SETTLE_RST,
    default: '0
  };
endpackage

// >>> rtl/sdcc_core.sv
// Purpose: sinc3 decimation, settling, calibration and standby control
// Assumes: clk_i is the master clock, modulator bit sampled on mod_en_o
// Notes: all state lives in one struct, registered once per clock
//
// What this block does
// - notch defaults to sixty hertz after reset
// - notch programmable between its lower and upper limits
// - sinc3 filter refreshes output once per notch period
// - control write starts calibration only while no calibration is running
// - self calibration keeps coefficients in on-chip storage
// - system calibration removes channel offset and gain
// - background mode recalibrates repeatedly without commands
// - host reads and overwrites calibration coefficients
// - software standby stops conversion activity
// - two channels, gain one to one-twenty-eight
// - input sampled at gain-scaled master clock rate
// - results invalid until filter settling has elapsed
// - twelve-bit notch select field picks the notch
// - channel change settles in three periods
// - sync low resets filter, three-period settling
// - modulator runs at master clock over 512
`timescale 1ns/1ps
module sdcc_core #(
  parameter int BG_GAP = sdcc_pkg::BG_GAP_DEF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mod_bit_i,
  input wire logic sync_n_i,
  input wire logic standby_i,
  input wire logic cfg_wr_i,
  input wire logic chan_i,
  input wire logic [2:0] gain_i,
  input wire logic [11:0] notch_select_field_i,
  input wire logic [1:0] cal_mode_i,
  input wire logic coef_sel_i,
  input wire logic coef_wr_i,
  input wire logic [23:0] coef_wdata_i,
  output logic [23:0] data_o,
  output logic data_ready_o,
  output logic data_valid_o,
  output logic [23:0] coef_rdata_o,
  output logic cal_busy_o,
  output logic [1:0] cal_phase_o,
  output logic cal_internal_o,
  output logic cal_ovf_o,
  output logic mod_en_o,
  output logic sample_en_o,
  output logic chan_o,
  output logic [2:0] gain_o,
  output logic [11:0] notch_o,
  output logic standby_o
);
  if (BG_GAP < 1 || BG_GAP > 256)
  begin : g_bg_gap_chk
    $error("BG_GAP must lie in 1..256");
  end

  localparam logic [7:0] BG_LAST = 8'(BG_GAP - 1);

  function automatic logic [23:0] sat24(input logic [49:0] v);
    if (v[49:23] == {27{v[23]}})
      return v[23:0];
    return v[49] ? 24'h800000 : 24'h7FFFFF;
  endfunction

  function automatic logic [11:0] clamp_notch(input logic [11:0] v);
    if (v < sdcc_pkg::CODE_MIN)
      return sdcc_pkg::CODE_MIN;
    if (v > sdcc_pkg::CODE_MAX)
      return sdcc_pkg::CODE_MAX;
    return v;
  endfunction

  // sample period is 256 master clocks divided by min(gain, 8)
  function automatic logic samp_hit(input logic [8:0] cnt, input logic [2:0] g);
    logic [2:0] lg;
    lg = (g > 3'(sdcc_pkg::SAMP_MULT_LOG_MAX)) ? 3'(sdcc_pkg::SAMP_MULT_LOG_MAX) : g;
    return (cnt[7:0] & (8'hFF >> lg)) == 8'h00;
  endfunction

  sdcc_pkg::sdcc_state_t s;
  sdcc_pkg::sdcc_state_t n;

  logic [35:0] c1;
  logic [35:0] c2;
  logic [35:0] c3;
  logic [23:0] raw_w;
  logic [24:0] diff_w;
  logic signed [49:0] prod_w;
  logic [23:0] corr_w;
  logic last_w;

  assign c1 = s.i3 + s.i2 - s.d1; // i3 as this step leaves it, so three periods settle exactly
  assign c2 = c1 - s.d2;
  assign c3 = c2 - s.d3;
  assign raw_w = sat24({{14{c3[35]}}, c3});
  assign diff_w = {raw_w[23], raw_w} - {s.off_c[23], s.off_c};
  assign prod_w = $signed(diff_w) * $signed({1'b0, s.gain_c});
  assign corr_w = sat24(prod_w >>> sdcc_pkg::GAIN_SHIFT);
  assign last_w = s.dec == s.notch - 12'h001;

  always_comb
  begin
    logic filt_rst;
    logic ev;
    logic [2:0] sd;
    logic [24:0] rsh;
    logic qb;
    logic [23:0] sp;
    filt_rst = 1'b0;
    rsh = '0;
    qb = 1'b0;
    sp = '0;
    n = s;
    n.mod_en = 1'b0;
    n.samp_en = 1'b0;
    n.rdy = 1'b0;
    if (!standby_i)
    begin
      n.div = s.div + 9'h001;
      n.mod_en = s.div == sdcc_pkg::MOD_LAST;
      n.samp_en = samp_hit(s.div, s.gain);
    end
    ev = s.mod_en && last_w;
    sd = (s.settle == 3'h0) ? 3'h0 : s.settle - 3'h1;
    if (s.mod_en)
    begin
      n.i1 = s.i1 + {{35{~mod_bit_i}}, 1'b1};
      n.i2 = s.i2 + s.i1;
      n.i3 = s.i3 + s.i2;
      n.dec = last_w ? 12'h000 : s.dec + 12'h001;
    end
    if (ev)
    begin
      n.d1 = s.i3 + s.i2;
      n.d2 = c1;
      n.d3 = c2;
      n.settle = sd;
      unique case (s.st)
        sdcc_pkg::SDCC_ST_RUN:
        begin
          n.dout = corr_w;
          n.rdy = 1'b1;
          n.valid = sd == 3'h0;
          if (s.bg)
          begin
            n.bgcnt = (s.bgcnt == BG_LAST) ? 8'h00 : s.bgcnt + 8'h01;
            if (s.bgcnt == BG_LAST)
            begin
              n.st = sdcc_pkg::SDCC_ST_ZERO;
              n.sys = 1'b0;
              filt_rst = 1'b1;
              n.settle = sdcc_pkg::SETTLE_CAL;
            end
          end
        end
        sdcc_pkg::SDCC_ST_ZERO:
        begin
          if (sd == 3'h0)
          begin
            n.off_c = raw_w;
            n.st = sdcc_pkg::SDCC_ST_FULL;
            filt_rst = 1'b1;
            n.settle = sdcc_pkg::SETTLE_CAL;
          end
        end
        sdcc_pkg::SDCC_ST_FULL:
        begin
          if (sd == 3'h0)
          begin
            sp = raw_w - s.off_c;
            n.span = (sp[23] || sp == 24'h000000) ? 24'h000001 : sp;
            n.rem = '0;
            n.quo = '0;
            n.ovf = 1'b0;
            n.dcnt = sdcc_pkg::DIV_TOP;
            n.st = sdcc_pkg::SDCC_ST_DIV;
          end
        end
        sdcc_pkg::SDCC_ST_DIV:
        begin
        end
      endcase
    end
    // gain coefficient = 2^44 / span, one quotient bit per clock
    if (s.st == sdcc_pkg::SDCC_ST_DIV)
    begin
      rsh = {s.rem[23:0], s.dcnt == sdcc_pkg::DIV_TOP};
      qb = rsh >= {1'b0, s.span};
      n.rem = qb ? rsh - {1'b0, s.span} : rsh;
      n.quo = {s.quo[22:0], qb};
      n.ovf = s.ovf | s.quo[23];
      n.dcnt = s.dcnt - 6'h01;
      if (s.dcnt == 6'h00)
      begin
        n.gain_c = (s.ovf | s.quo[23]) ? 24'hFFFFFF : {s.quo[22:0], qb};
        n.st = sdcc_pkg::SDCC_ST_RUN;
        filt_rst = 1'b1;
        n.settle = sdcc_pkg::SETTLE_CAL;
      end
    end
    if (cfg_wr_i)
    begin
      n.notch = clamp_notch(notch_select_field_i);
      n.dec = (n.notch != s.notch) ? 12'h000 : n.dec; // never left above the new wrap
      n.gain = gain_i;
      n.chan = chan_i;
      if (n.notch != s.notch || gain_i != s.gain)
        n.settle = sdcc_pkg::SETTLE_STEP;
      if (chan_i != s.chan)
      begin
        filt_rst = 1'b1;
        n.settle = sdcc_pkg::SETTLE_CHAN;
      end
      if (cal_mode_i == sdcc_pkg::SDCC_CAL_NONE)
        n.bg = 1'b0;
      else if (s.st == sdcc_pkg::SDCC_ST_RUN)
      begin
        n.st = sdcc_pkg::SDCC_ST_ZERO;
        n.sys = cal_mode_i == sdcc_pkg::SDCC_CAL_SYS;
        n.bg = cal_mode_i == sdcc_pkg::SDCC_CAL_BG;
        n.bgcnt = 8'h00;
        filt_rst = 1'b1;
        n.settle = sdcc_pkg::SETTLE_CAL;
      end
    end
    if (coef_wr_i && s.st == sdcc_pkg::SDCC_ST_RUN)
    begin
      if (coef_sel_i)
        n.gain_c = coef_wdata_i;
      else
        n.off_c = coef_wdata_i;
    end
    if (!sync_n_i)
    begin
      filt_rst = 1'b1;
      n.settle = sdcc_pkg::SETTLE_SYNC;
    end
    if (filt_rst)
    begin
      n.i1 = '0;
      n.i2 = '0;
      n.i3 = '0;
      n.d1 = '0;
      n.d2 = '0;
      n.d3 = '0;
      n.dec = '0;
    end
    if (n.settle != 3'h0)
      n.valid = 1'b0;
    n.busy = n.st != sdcc_pkg::SDCC_ST_RUN;
    n.intl = n.busy && !n.sys;
    n.stby = standby_i;
    n.coef_rd = coef_sel_i ? s.gain_c : s.off_c;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s <= sdcc_pkg::STATE_RST;
    else
      s <= n;
  end

  assign data_o = s.dout;
  assign data_ready_o = s.rdy;
  assign data_valid_o = s.valid;
  assign coef_rdata_o = s.coef_rd;
  assign cal_busy_o = s.busy;
  assign cal_phase_o = s.st;
  assign cal_internal_o = s.intl;
  assign cal_ovf_o = s.ovf;
  assign mod_en_o = s.mod_en;
  assign sample_en_o = s.samp_en;
  assign chan_o = s.chan;
  assign gain_o = s.gain;
  assign notch_o = s.notch;
  assign standby_o = s.stby;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_notch_default;
    !$past(rst_n_i) |-> s.notch == sdcc_pkg::CODE_DEF;
  endproperty
  a_notch_default: assert property (p_notch_default) else $error("notch not default");

  property p_notch_range;
    s.notch >= sdcc_pkg::CODE_MIN && s.notch <= sdcc_pkg::CODE_MAX;
  endproperty
  a_notch_range: assert property (p_notch_range) else $error("notch out of range");

  property p_mod_rate;
    mod_en_o |=> !mod_en_o [*8];
  endproperty
  a_mod_rate: assert property (p_mod_rate) else $error("modulator rate wrong");

  property p_cal_start;
    cfg_wr_i && cal_mode_i != 2'h0 && s.st == sdcc_pkg::SDCC_ST_RUN && sync_n_i
      |=> cal_phase_o == 2'h1 && cal_busy_o && s.settle == sdcc_pkg::SETTLE_CAL;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration not started");

  property p_coef_wr;
    coef_wr_i && !cal_busy_o |=> ##1 coef_rdata_o == $past(coef_wdata_i, 2)
      || $past(coef_sel_i) != $past(coef_sel_i, 2);
  endproperty
  a_coef_wr: assert property (p_coef_wr) else $error("coefficient not written");

  property p_standby;
    standby_i |=> !mod_en_o && !sample_en_o && standby_o;
  endproperty
  a_standby: assert property (p_standby) else $error("activity in standby");

  property p_valid;
    data_valid_o |-> s.settle == 3'h0 && !cal_busy_o;
  endproperty
  a_valid: assert property (p_valid) else $error("valid before settling");

  property p_sync;
    !sync_n_i |=> s.i3 == '0 && s.dec == '0 && s.settle == 3'h3;
  endproperty
  a_sync: assert property (p_sync) else $error("sync did not reset filter");

  property p_chan;
    cfg_wr_i && chan_i != chan_o && cal_mode_i == 2'h0 && sync_n_i
      |=> s.settle == 3'h3 && s.i1 == '0 && !data_valid_o;
  endproperty
  a_chan: assert property (p_chan) else $error("channel settle wrong");

  property p_ready;
    data_ready_o |-> $past(s.dec) == $past(s.notch) - 12'h001 && !$past(cal_busy_o);
  endproperty
  a_ready: assert property (p_ready) else $error("update off notch period");
endmodule
